// >>> common/ext_bus_pkg.sv
// Package: constants and carrier types for the external bus mode control block
package ext_bus_pkg;

    // ****************************************************************
    // Widths and positions
    // ****************************************************************
    localparam int unsigned ADDR_W        = 16;
    localparam int unsigned STATUS_W      = 16;
    localparam int unsigned BOOT_BIT_POS  = 2;   // Boot select copy in status word two
    localparam logic [15:0] BOOT_VECTOR   = 16'h0000;
    localparam logic [15:0] STATUS_RST    = 16'h0000;

    // Space encodings on the request carrier
    localparam logic [1:0]  SPACE_PROG    = 2'h0;
    localparam logic [1:0]  SPACE_DATA    = 2'h1;
    localparam logic [1:0]  SPACE_IO      = 2'h2;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_RESET = 3'b001,
        ST_MICROCOMPUTER = 3'b010,
        ST_MICROPROCESSOR = 3'b100
    } boot_state_t;

    // Core side request for an external access
    typedef struct packed {
        logic        valid;
        logic [1:0]  space;
        logic        write;
        logic [15:0] addr;
    } ext_req_t;

    // Fetch start presented to the core after reset
    typedef struct packed {
        logic        external;
        logic [15:0] addr;
    } boot_vec_t;

endpackage : ext_bus_pkg

// >>> dv/ext_mem_model.sv
// Partner model: external memory decode that latches strobed addresses
`timescale 1ns/1ps
module ext_mem_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ext_active,
    input  wire logic [15:0] ext_addr,
    output logic      [15:0] last_addr_ff,
    output logic      [7:0]  hits_ff
);
    // Decode only on the strobe, so idle bus values never count as accesses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_addr_ff <= 16'h0000;
            hits_ff      <= 8'h00;
        end else if (ext_active) begin
            last_addr_ff <= ext_addr;
            hits_ff      <= hits_ff + 8'h01;
        end
    end
endmodule : ext_mem_model

// >>> dv/test_ext_bus_mode_control.sv
// Testbench: boot capture, access gating and visibility enable
`timescale 1ns/1ps
module test_ext_bus_mode_control;
    // ****************************************************************
    // Stimulus, design and partner
    // ****************************************************************
    logic clk, rst = 1'b1, boot_location_select = 1'b0, external_interface_enable = 1'b0;
    logic visibility_mode = 1'b0, data_bus_drive = 1'b0, ext_active, illegal_address, boot_done;
    logic visibility_output_enable_n;
    logic [15:0] ext_addr, system_control_status_two, last_addr;
    logic [7:0] hits;
    ext_bus_pkg::ext_req_t req = '0;
    ext_bus_pkg::boot_vec_t boot_vec;
    int miscompares = 0, compares = 0, cycles = 0;
    ext_bus_mode_control ext_bus_mode_control_i (.clk, .rst, .boot_location_select,
        .external_interface_enable, .visibility_mode, .data_bus_drive, .req, .ext_addr,
        .ext_active, .illegal_address, .visibility_output_enable_n,
        .system_control_status_two, .boot_vec, .boot_done);
    ext_mem_model ext_mem_model_i (.clk, .rst, .ext_active, .ext_addr,
        .last_addr_ff(last_addr), .hits_ff(hits));
    // Free running clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Hang guard: the whole run needs under a hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            final_report();
        end
    end
    // ****************************************************************
    // Compare and report
    // ****************************************************************
    task check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check_word
    task final_report;
        if (miscompares == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Reset with a strap level; visibility inputs drop a cycle before release
    // so no antecedent sampled in reset is judged against the first free cycle
    task boot_check(input logic strap);
        @(posedge clk);
        {rst, boot_location_select, visibility_mode, data_bus_drive} <= {1'b1, strap, 2'b11};
        repeat (4) @(posedge clk);
        check_word("oe_n_in_reset", 16'h0001, 16'(visibility_output_enable_n));
        {visibility_mode, data_bus_drive} <= 2'b00;
        @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check_word("boot_done_early", 16'h0000, 16'(boot_done));
        @(posedge clk);
        #1 check_word("boot_done", 16'h0001, 16'(boot_done));
        check_word("boot_external", 16'(strap), 16'(boot_vec.external));
        check_word("boot_addr", 16'h0000, boot_vec.addr);
        check_word("status_two", {13'h0000, strap, 2'h0}, system_control_status_two);
        @(posedge clk);
        boot_location_select <= ~strap;
        repeat (4) @(posedge clk);
        #1 check_word("status_late", {13'h0000, strap, 2'h0}, system_control_status_two);
        check_word("boot_late", 16'(strap), 16'(boot_vec.external));
    endtask : boot_check
    // One request cycle, then the answer in the following cycle
    task access(input logic [1:0] space, input logic [15:0] addr, input logic en);
        @(posedge clk);
        req <= {1'b1, space, 1'b0, addr};
        @(posedge clk);
        req.valid <= 1'b0;
        #1 check_word("ext_active", 16'(en && space != 2'h3), 16'(ext_active));
        check_word("illegal", 16'(!en && space != 2'h3), 16'(illegal_address));
        if (en && space != 2'h3) check_word("ext_addr", addr, ext_addr);
    endtask : access
    task enabled_access;
        @(posedge clk);
        external_interface_enable <= 1'b1;
        repeat (3) @(posedge clk);
        access(ext_bus_pkg::SPACE_PROG, 16'h0000, 1'b1);
        access(ext_bus_pkg::SPACE_DATA, 16'hffff, 1'b1);
        access(ext_bus_pkg::SPACE_IO, 16'ha5a5, 1'b1);
        access(2'h3, 16'h1234, 1'b1);
        check_word("partner_hits", 16'h0003, 16'(hits));
        check_word("partner_addr", 16'ha5a5, last_addr);
    endtask : enabled_access
    // Enable low: every space refused, address bus keeps its last value
    task disabled_access;
        @(posedge clk);
        external_interface_enable <= 1'b0;
        repeat (3) @(posedge clk);
        for (int s = 0; s < 4; s++) access(2'(s), 16'h5a5a, 1'b0);
        check_word("addr_held", 16'ha5a5, ext_addr);
        check_word("partner_idle", 16'h0003, 16'(hits));
    endtask : disabled_access
    // Every pairing of mode and drive; only both high pulls the enable low
    task visibility;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {visibility_mode, data_bus_drive} <= 2'(i);
            @(posedge clk);
            #1 check_word("visibility_output_enable_n_n", 16'(i != 3), 16'(visibility_output_enable_n));
        end
    endtask : visibility
    initial begin
        repeat (16) @(posedge clk);
        boot_check(1'b0);
        boot_check(1'b1);
        enabled_access();
        disabled_access();
        visibility();
        final_report();
    end
endmodule : test_ext_bus_mode_control

// >>> src/ext_bus_mode_control.sv
// Module: boot mode capture, external interface gating and visibility enable
`timescale 1ns/1ps

// What this block does
// [R1] A low boot select at reset selects microcomputer mode, starting at 0000h internal.
// [R2] A high boot select at reset selects microprocessor mode, starting at 0000h external.
// [R3] The boot select level caught at reset sits in bit 2 of status word two.
// [R4] External interface signals are active only while the interface enable is high.
// [R5] With the enable low every external program, data or I/O access flags an illegal address.
// [R6] In visibility mode the visibility enable goes low while the data bus is driven.
// [R7] External addresses leave on a 16-bit bus, bits 0 to 15.
// [R8] The visibility enable stays high whenever the data bus is not driven in visibility mode.
module ext_bus_mode_control #(
    parameter int unsigned ADDR_W = ext_bus_pkg::ADDR_W
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  boot_location_select,
    input  wire logic                  external_interface_enable,
    input  wire logic                  visibility_mode,
    input  wire logic                  data_bus_drive,
    input  wire ext_bus_pkg::ext_req_t req,
    output logic [ADDR_W-1:0]          ext_addr,
    output logic                       ext_active,
    output logic                       illegal_address,
    output logic                       visibility_output_enable_n,
    output logic [15:0]                system_control_status_two,
    output ext_bus_pkg::boot_vec_t     boot_vec,
    output logic                       boot_done
);

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    if (ADDR_W != 16) begin : g_bad_width
        $error("Address bus must be 16 bits wide");
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic boot_sel_meta_ff;
    logic boot_sel_ff;
    logic ena_meta_ff;
    logic ena_ff;

    // Two flops per pin; the first stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            boot_sel_meta_ff <= 1'b0;
            boot_sel_ff      <= 1'b0;
            ena_meta_ff      <= 1'b0;
            ena_ff           <= 1'b0;
        end else begin
            boot_sel_meta_ff <= boot_location_select;
            boot_sel_ff      <= boot_sel_meta_ff;
            ena_meta_ff      <= external_interface_enable;
            ena_ff           <= ena_meta_ff;
        end
    end

    // ****************************************************************
    // Boot mode capture
    // ****************************************************************
    ext_bus_pkg::boot_state_t state_ff;
    ext_bus_pkg::boot_state_t nxt_state;
    logic                     settle_early_ff;
    logic                     settle_ff;

    // Strap cannot load under async reset; two flops so the sync chain holds the pin first
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settle_early_ff <= 1'b0;
            settle_ff       <= 1'b0;
        end else begin
            settle_early_ff <= 1'b1;
            settle_ff       <= settle_early_ff;
        end
    end

    // [R1] [R2] mode select
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ext_bus_pkg::ST_RESET: begin
                if (settle_ff) begin
                    nxt_state = boot_sel_ff ? ext_bus_pkg::ST_MICROPROCESSOR
                                            : ext_bus_pkg::ST_MICROCOMPUTER;
                end
            end
            ext_bus_pkg::ST_MICROCOMPUTER:  nxt_state = state_ff;
            ext_bus_pkg::ST_MICROPROCESSOR: nxt_state = state_ff;
            default:                        nxt_state = ext_bus_pkg::ST_RESET;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= ext_bus_pkg::ST_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // [R1] [R2] boot vector
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            boot_vec  <= '0;
            boot_done <= 1'b0;
        end else if (state_ff == ext_bus_pkg::ST_RESET && settle_ff) begin
            boot_vec.external <= boot_sel_ff;
            boot_vec.addr     <= ext_bus_pkg::BOOT_VECTOR;
            boot_done         <= 1'b1;
        end
    end

    // [R3] status bit copy
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            system_control_status_two <= ext_bus_pkg::STATUS_RST;
        end else if (state_ff == ext_bus_pkg::ST_RESET && settle_ff) begin
            system_control_status_two[ext_bus_pkg::BOOT_BIT_POS] <= boot_sel_ff;
        end
    end

    // ****************************************************************
    // External access gating
    // ****************************************************************
    logic space_ok;
    assign space_ok = req.space == ext_bus_pkg::SPACE_PROG ||
                      req.space == ext_bus_pkg::SPACE_DATA ||
                      req.space == ext_bus_pkg::SPACE_IO;

    // [R4] [R7] enable gates the address bus; address held when idle to save toggling
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_addr   <= '0;
            ext_active <= 1'b0;
        end else begin
            ext_active <= req.valid && space_ok && ena_ff;
            if (req.valid && space_ok && ena_ff) begin
                ext_addr <= req.addr;
            end
        end
    end

    // [R5] illegal address flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            illegal_address <= 1'b0;
        end else begin
            illegal_address <= req.valid && space_ok && !ena_ff;
        end
    end

    // ****************************************************************
    // Visibility output enable
    // ****************************************************************
    // [R6] [R8] low only while driving in visibility mode; inputs are core-side logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            visibility_output_enable_n <= 1'b1;
        end else begin
            visibility_output_enable_n <= !(visibility_mode && data_bus_drive);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_MICROCOMPUTER: assert property (@(posedge clk) disable iff (rst) // [R1]
        (state_ff == ext_bus_pkg::ST_RESET && settle_ff && !boot_sel_ff) |=>
        (state_ff == ext_bus_pkg::ST_MICROCOMPUTER && !boot_vec.external &&
         boot_vec.addr == ext_bus_pkg::BOOT_VECTOR))
        else $error("Low boot select did not give internal start");

    AST_MICROPROCESSOR: assert property (@(posedge clk) disable iff (rst) // [R2]
        (state_ff == ext_bus_pkg::ST_RESET && settle_ff && boot_sel_ff) |=>
        (state_ff == ext_bus_pkg::ST_MICROPROCESSOR && boot_vec.external && boot_done))
        else $error("High boot select did not give external start");

    AST_STATUS_BIT: assert property (@(posedge clk) disable iff (rst) // [R3]
        boot_done |-> system_control_status_two[2] == boot_vec.external)
        else $error("Status bit does not match boot mode");

    AST_MODE_STICKY: assert property (@(posedge clk) disable iff (rst) // [R3]
        boot_done |=> $stable(system_control_status_two) && $stable(state_ff))
        else $error("Boot mode changed after capture");

    AST_ENABLE_GATE: assert property (@(posedge clk) disable iff (rst) // [R4]
        ext_active |-> $past(ena_ff) && !illegal_address)
        else $error("External access while interface disabled");

    AST_ILLEGAL: assert property (@(posedge clk) disable iff (rst) // [R5]
        (req.valid && space_ok && !ena_ff) |=> illegal_address && !ext_active)
        else $error("Disabled access not flagged illegal");

    AST_ADDR_PASS: assert property (@(posedge clk) disable iff (rst) // [R7]
        (req.valid && space_ok && ena_ff) |=> ext_addr == $past(req.addr))
        else $error("Address bus not carrying request address");

    AST_VIS_LOW: assert property (@(posedge clk) disable iff (rst) // [R6]
        (visibility_mode && data_bus_drive) |=> !visibility_output_enable_n)
        else $error("Visibility enable not low while driving");

    AST_VIS_HIGH: assert property (@(posedge clk) disable iff (rst) // [R8]
        !(visibility_mode && data_bus_drive) |=> visibility_output_enable_n)
        else $error("Visibility enable low while not driving");

endmodule : ext_bus_mode_control
